// File: verilog/lks_consts.vh
// Purpose: constants for the led and key scan multiplexer
// Assumes: 40 MHz clock, 25 ns period
// Notes:   header only, no logic
`ifndef LKS_CONSTS_VH
`define LKS_CONSTS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define LKS_NUM_COLUMNS       8
`define LKS_SEG_ROWS          8
`define LKS_LAMP_ROWS         30
`define LKS_LAMP_ROWS_0       15
`define LKS_KEY_ROWS          7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LKS_COLUMN_RESET      8'hff
`define LKS_ROW_RESET         8'h00
`define LKS_KEY_RESET         7'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LKS_CLK_PERIOD_PS     25000
`define LKS_TIMEOUT_MS        6
// scaled to ns per cycle so the product stays inside 32-bit integer math
`define LKS_TIMEOUT_CYCLES    ((`LKS_TIMEOUT_MS * 1000000) / (`LKS_CLK_PERIOD_PS / 1000))

`endif

// File: verilog/lks_retrigger_timer.v
// Purpose: retriggerable timeout, active while triggers keep coming
// Assumes: one trigger pulse per column strobe write
// Notes:   a trigger reloads the full count
`timescale 1ns/1ps

module lks_retrigger_timer #(
    parameter integer TIMEOUT_CYCLES = 240000,
    parameter integer CW             = 18
) (
    input  wire i_clk,
    input  wire i_reset_n,
    input  wire i_trigger,
    output reg  o_active
);

    reg [CW-1:0] count;
    localparam [CW-1:0] LOAD_VALUE = TIMEOUT_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count    <= {CW{1'b0}};
            o_active <= 1'b0;
        end else if (i_trigger) begin
            count    <= LOAD_VALUE; // RQ8
            o_active <= 1'b1;       // RQ14
        end else if (count != {CW{1'b0}}) begin
            count    <= count - {{(CW-1){1'b0}}, 1'b1};
        end else begin
            o_active <= 1'b0;       // RQ8
        end
    end

endmodule

// File: verilog/lks_scan_mux.v
// Purpose: led matrix drive and key matrix sense for a multiplexed front panel
// Assumes: host writes column word and row words each strobe, inputs synchronous
// Notes:   drivers blank when strobes stop for the timeout period
//
// How it works
// RQ1: the host cycles eight columns one after another in a rotation.
// RQ2: an indicator lights only when its row and column are both driven.
// RQ3: each column strobe lasts about 2 ms before the host advances.
// RQ4: the host writes all row words at the start of each strobe.
// RQ5: two segment bank clocks and two lamp clocks load the row words.
// RQ6: the column word holds one low bit enabling one column source.
// RQ7: latched high row bits turn on their row current sinks.
// RQ8: a retriggerable timeout disables the registers after 6 ms without strobe.
// RQ9: while disabled, all row sinks and column sources are forced off.
// RQ10: closed keys drive their sense row high during their column strobe.
// RQ11: the host reads the key latch once during each column strobe.
// RQ12: sense rows of unpressed keys read back as zero.
// RQ13: after reset columns are inactive and rows are off.
// RQ14: each strobe write retriggers the timeout and re-enables the registers.
`timescale 1ns/1ps
`include "lks_consts.vh"

module lks_scan_mux #(
    parameter integer NUM_COLUMNS    = `LKS_NUM_COLUMNS,
    parameter integer SEG_ROWS       = `LKS_SEG_ROWS,
    parameter integer LAMP_ROWS      = `LKS_LAMP_ROWS,
    parameter integer LAMP_ROWS_0    = `LKS_LAMP_ROWS_0,
    parameter integer KEY_ROWS       = `LKS_KEY_ROWS,
    parameter integer TIMEOUT_CYCLES = `LKS_TIMEOUT_CYCLES
) (
    input  wire                       i_clk,
    input  wire                       i_reset_n,
    input  wire                       i_column_strobe_write,
    input  wire [NUM_COLUMNS-1:0]     i_column_word_n,
    input  wire                       i_segment_bank_a_clock,
    input  wire                       i_segment_bank_b_clock,
    input  wire [SEG_ROWS-1:0]        i_segment_row_data,
    input  wire                       i_lamp_row_clock_0,
    input  wire                       i_lamp_row_clock_1,
    input  wire [LAMP_ROWS_0-1:0]     i_lamp_row_data,
    input  wire                       i_key_latch_read,
    input  wire [KEY_ROWS-1:0]        i_switch_sense_rows,
    output reg  [NUM_COLUMNS-1:0]     o_column_strobes_n,
    output reg  [SEG_ROWS-1:0]        o_segment_bank_a_rows,
    output reg  [SEG_ROWS-1:0]        o_segment_bank_b_rows,
    output reg  [LAMP_ROWS-1:0]       o_lamp_rows,
    output reg  [KEY_ROWS-1:0]        o_key_latch,
    output reg                        o_drivers_enabled
);

    localparam integer LAMP_ROWS_1 = LAMP_ROWS - LAMP_ROWS_0;

    // ----------------------------------------------------------------
    // holding registers
    // ----------------------------------------------------------------
    reg  [NUM_COLUMNS-1:0] column_word_n;
    reg  [SEG_ROWS-1:0]    bank_a_word;
    reg  [SEG_ROWS-1:0]    bank_b_word;
    reg  [LAMP_ROWS-1:0]   lamp_word;
    wire                   timer_active;
    wire                   enable_now;
    wire [NUM_COLUMNS-1:0] next_column_strobes_n;
    reg  [NUM_COLUMNS-1:0] onehot_n;
    wire [NUM_COLUMNS:0]   low_seen;
    wire [NUM_COLUMNS:0]   low_twice;
    reg  [SEG_ROWS-1:0]    next_bank_a_rows;
    reg  [SEG_ROWS-1:0]    next_bank_b_rows;
    reg  [LAMP_ROWS-1:0]   next_lamp_rows;
    genvar                 g;

    // ----------------------------------------------------------------
    // timeout
    // ----------------------------------------------------------------
    lks_retrigger_timer #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
        .CW             (32)
    ) u_timer (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_trigger (i_column_strobe_write),
        .o_active  (timer_active)
    );

    // a strobe write enables key capture in its own cycle, before timer_active rises
    assign enable_now = timer_active | i_column_strobe_write; // RQ14

    // ----------------------------------------------------------------
    // column word: accept only one low bit, else all columns off
    // ----------------------------------------------------------------
    // guards against two columns sharing a row sink and doubling current;
    // a ripple chain per column marks the first and any second low bit
    assign low_seen[0]  = 1'b0;
    assign low_twice[0] = 1'b0;

    generate
        for (g = 0; g < NUM_COLUMNS; g = g + 1) begin : g_low_count
            assign low_seen[g+1]  = low_seen[g] | ~column_word_n[g];
            assign low_twice[g+1] = low_twice[g] | (low_seen[g] & ~column_word_n[g]);
        end
    endgenerate

    always @* begin
        if (low_seen[NUM_COLUMNS] && !low_twice[NUM_COLUMNS]) begin
            onehot_n = column_word_n; // RQ6
        end else begin
            onehot_n = {NUM_COLUMNS{1'b1}};
        end
    end

    assign next_column_strobes_n = timer_active ? onehot_n : {NUM_COLUMNS{1'b1}}; // RQ9

    // ----------------------------------------------------------------
    // row gating
    // ----------------------------------------------------------------
    // holding registers keep loading while blanked, so the first strobe
    // after a timeout shows the newest rows at once
    always @* begin
        if (timer_active) begin
            next_bank_a_rows = bank_a_word;       // RQ7
            next_bank_b_rows = bank_b_word;       // RQ7
            next_lamp_rows   = lamp_word;         // RQ7
        end else begin
            next_bank_a_rows = {SEG_ROWS{1'b0}};  // RQ9
            next_bank_b_rows = {SEG_ROWS{1'b0}};  // RQ9
            next_lamp_rows   = {LAMP_ROWS{1'b0}}; // RQ9
        end
    end

    // ----------------------------------------------------------------
    // row and column latches
    // ----------------------------------------------------------------
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            column_word_n <= `LKS_COLUMN_RESET; // RQ13
            bank_a_word   <= {SEG_ROWS{1'b0}};  // RQ13
            bank_b_word   <= {SEG_ROWS{1'b0}};
            lamp_word     <= {LAMP_ROWS{1'b0}};
        end else begin
            if (i_column_strobe_write) begin
                column_word_n <= i_column_word_n; // RQ6
            end
            if (i_segment_bank_a_clock) begin
                bank_a_word <= i_segment_row_data; // RQ5
            end
            if (i_segment_bank_b_clock) begin
                bank_b_word <= i_segment_row_data; // RQ5
            end
            if (i_lamp_row_clock_0) begin
                lamp_word[LAMP_ROWS_0-1:0] <= i_lamp_row_data; // RQ5
            end
            if (i_lamp_row_clock_1) begin
                lamp_word[LAMP_ROWS-1:LAMP_ROWS_0] <= i_lamp_row_data[LAMP_ROWS_1-1:0]; // RQ5
            end
        end
    end

    // ----------------------------------------------------------------
    // output drivers, forced off while the timeout has expired
    // ----------------------------------------------------------------
    // row sinks and column sources both gate on the same enable, so a lit
    // indicator needs an active column and a set row together
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_column_strobes_n    <= `LKS_COLUMN_RESET; // RQ13
            o_segment_bank_a_rows <= {SEG_ROWS{1'b0}};
            o_segment_bank_b_rows <= {SEG_ROWS{1'b0}};
            o_lamp_rows           <= {LAMP_ROWS{1'b0}};
            o_drivers_enabled     <= 1'b0;
        end else begin
            o_drivers_enabled     <= timer_active;          // RQ8
            o_column_strobes_n    <= next_column_strobes_n; // RQ2
            o_segment_bank_a_rows <= next_bank_a_rows;      // RQ2
            o_segment_bank_b_rows <= next_bank_b_rows;      // RQ2
            o_lamp_rows           <= next_lamp_rows;        // RQ2
        end
    end

    // ----------------------------------------------------------------
    // key latch
    // ----------------------------------------------------------------
    // captured on the host read; undriven sense rows are assumed pulled low
    // outside, and keys are only trusted while the timeout runs or a strobe write is present
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_key_latch <= `LKS_KEY_RESET;
        end else if (i_key_latch_read) begin
            if (enable_now) begin
                o_key_latch <= i_switch_sense_rows; // RQ10
            end else begin
                o_key_latch <= {KEY_ROWS{1'b0}};    // RQ12
            end
        end
    end

endmodule

// File: verif/lks_host_model.sv
// Purpose: host that writes scan words, holds keys
// Assumes: column period cut to ten cycles
// Notes:   open keys read low via pull-downs
`timescale 1ns/1ps
module lks_host_model (
    input  wire        i_clk,
    output reg  [36:0] o_drv,
    output wire [6:0]  o_sense
);
    reg [6:0] keys [0:7];
    reg [2:0] col = 3'h0;
    integer   k;
    assign o_sense = keys[col];
    initial o_drv = 37'h0;
    initial for (k = 0; k < 8; k = k + 1) keys[k] = 7'h0;
    // data not qualified by a clock is inverted, the column word all ones before its strobe, so stale values never look valid
    task scan(input [2:0] c, input [7:0] w, a, b, input [29:0] l);
        @(negedge i_clk) o_drv = {6'h10, 8'hff, a, ~l[14:0]};
        @(negedge i_clk) o_drv = {6'h08, 8'hff, b, ~l[14:0]};
        @(negedge i_clk) o_drv = {6'h04, 8'hff, ~b, l[14:0]};
        @(negedge i_clk) o_drv = {6'h02, 8'hff, ~b, l[29:15]};
        @(negedge i_clk) {o_drv, col} = {6'h20, w, ~b, ~l[29:15], c};
        @(negedge i_clk) o_drv = {6'h01, ~w, ~b, ~l[29:15]};
        @(negedge i_clk) o_drv[36:31] = 6'h00;
        repeat (3) @(negedge i_clk);
    endtask
endmodule

// File: verif/lks_scan_chk.sv
// Purpose: port checks for the scan multiplexer
// Assumes: bound to lks_scan_mux, one clock
// Notes:   timeout bounds sit on the counter end points
`timescale 1ns/1ps
module lks_scan_chk #(parameter integer TIMEOUT_CYCLES = 50) (
    input wire       i_clk,
    input wire       i_reset_n,
    input wire       i_column_strobe_write,
    input wire [7:0] i_column_word_n,
    input wire       i_segment_bank_a_clock,
    input wire [7:0] i_segment_row_data,
    input wire [7:0] o_column_strobes_n,
    input wire [7:0] o_segment_bank_a_rows,
    input wire       o_drivers_enabled
);
    reg [31:0] gap;
    wire       wr = i_column_strobe_write;
    wire       good = $onehot(~i_column_word_n);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_load(d, q);
        ##2 (!o_drivers_enabled || q == $past(d, 2));
    endsequence
    // saturates so a long idle never wraps back into range
    always @(posedge i_clk or negedge i_reset_n)
        if (!i_reset_n)
            gap <= 32'hffffffff;
        else
            gap <= wr ? 32'h0 : gap + {31'h0, gap != 32'hffffffff};
    a_col_shown: assert property (wr && good |->
        s_load(i_column_word_n, o_column_strobes_n)) else $error("column lost");
    a_bad_blank: assert property (wr && !good |->
        ##2 o_column_strobes_n == 8'hff) else $error("bad word shown");
    a_en_rise: assert property (wr |-> ##2 o_drivers_enabled)
        else $error("not enabled");
    a_seg_load: assert property (i_segment_bank_a_clock |->
        s_load(i_segment_row_data, o_segment_bank_a_rows)) else $error("rows lost");
    a_one_col: assert property (o_column_strobes_n != 8'hff |->
        $onehot(~o_column_strobes_n)) else $error("two columns");
    a_dark_idle: assert property (!o_drivers_enabled && !$past(o_drivers_enabled) |->
        o_column_strobes_n == 8'hff && o_segment_bank_a_rows == 8'h00) else $error("lit");
    a_stay_on: assert property (gap >= 1 && gap <= TIMEOUT_CYCLES |->
        o_drivers_enabled) else $error("dropped early");
    a_time_out: assert property (gap >= TIMEOUT_CYCLES + 1 |->
        !o_drivers_enabled) else $error("no timeout");
endmodule
bind lks_scan_mux lks_scan_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (.*);

// File: verif/test_lks_scan_mux.sv
// Purpose: self-checking bench for the scan multiplexer
// Assumes: timeout cut to TO cycles
// Notes:   all outputs compared as one word
`timescale 1ns/1ps
module test_lks_scan_mux;
    localparam integer TO = 50;
    reg         clk = 1'b0, rst_n = 1'b0;
    reg  [61:0] exp;
    integer     errors = 0, samples_checked = 0, seed = 18367, n;
    wire [36:0] drv;
    wire [6:0]  sense;
    wire [61:0] seen;
    always #12.5 clk = ~clk;
    lks_host_model i_host (.i_clk(clk), .o_drv(drv), .o_sense(sense));
    lks_scan_mux #(.TIMEOUT_CYCLES(TO)) i_dut (.i_clk(clk), .i_reset_n(rst_n),
        .i_column_strobe_write(drv[36]), .i_segment_bank_a_clock(drv[35]),
        .i_segment_bank_b_clock(drv[34]), .i_lamp_row_clock_0(drv[33]),
        .i_lamp_row_clock_1(drv[32]), .i_key_latch_read(drv[31]), .i_column_word_n(drv[30:23]),
        .i_segment_row_data(drv[22:15]), .i_lamp_row_data(drv[14:0]), .i_switch_sense_rows(sense),
        .o_column_strobes_n(seen[61:54]), .o_segment_bank_a_rows(seen[53:46]),
        .o_segment_bank_b_rows(seen[45:38]), .o_lamp_rows(seen[37:8]), .o_key_latch(seen[7:1]),
        .o_drivers_enabled(seen[0]));
    task check(input [61:0] got, want);
        samples_checked = samples_checked + 1;
        if (got !== want) begin
            errors = errors + 1;
            $display("BAD outputs expected %h seen %h", want, got);
        end
        $display("test %0d done", samples_checked);
    endtask
    task stop_test;
        $display("%0d checks, %0d mismatches", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task run(input [2:0] c, input bad);
        reg [63:0] r;
        reg [7:0]  w;
        r = {$random(seed), $random(seed)};
        if (c == 3'h3)
            r[6:0] = 7'h0;
        w = bad ? (c[0] ? 8'h00 : 8'hfc) : ~(8'h01 << c);
        i_host.keys[c] = r[6:0];
        i_host.scan(c, w, r[52:45], r[44:37], r[36:7]);
        exp = {bad ? 8'hff : w, r[52:0], 1'b1};
        check(seen, exp);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        exp = {8'hff, 54'h0};
        check(seen, exp);
        for (n = 0; n < 18; n = n + 1)
            run(n[2:0], n > 15);
        repeat (TO - 15) @(negedge clk);
        run(3'h4, 1'b0);
        repeat (TO + 5) @(negedge clk);
        exp = {8'hff, 46'h0, exp[7:1], 1'b0};
        check(seen, exp);
        run(3'h6, 1'b0);
        rst_n = 1'b0;
        @(negedge clk);
        exp = {8'hff, 54'h0};
        check(seen, exp);
        stop_test;
    end
    // tests need about 300 cycles, so 2000 is ample
    initial begin
        #50000;
        errors = errors + 1;
        stop_test;
    end
endmodule
